// [design/rsp_consts.vh]
// Constants for the radio serial port host controller.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef RSP_CONSTS_VH
`define RSP_CONSTS_VH
`define RSP_CLK_PERIOD_PS     5000
`define RSP_SCLK_HALF_NS      50
`define RSP_SCLK_HALF_CYC     ((`RSP_SCLK_HALF_NS * 1000 + `RSP_CLK_PERIOD_PS - 1) / `RSP_CLK_PERIOD_PS)
`define RSP_BYTE_GAP_NS       100
`define RSP_BYTE_GAP_CYC      ((`RSP_BYTE_GAP_NS * 1000 + `RSP_CLK_PERIOD_PS - 1) / `RSP_CLK_PERIOD_PS)
`define RSP_PD_WAIT_US        150
`define RSP_PD_WAIT_CYC       ((`RSP_PD_WAIT_US * 1000000 + `RSP_CLK_PERIOD_PS - 1) / `RSP_CLK_PERIOD_PS)
`define RSP_SYNC_SETTLE_CYC   3
`define RSP_HDR_RW_BIT        7
`define RSP_HDR_BURST_BIT     6
`define RSP_STAT_RDY_BIT      7
`define RSP_STROBE_FIRST      6'h30
`define RSP_STROBE_LAST       6'h3D
`endif

// [design/rsp_fifo.v]
// Small synchronous FIFO, valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`default_nettype none
module rsp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             mclk,     // System clock
  input  wire             rst,      // Sync reset
  input  wire [WIDTH-1:0] inData,   // Write data
  input  wire             inValid,  // Write request
  output wire             inReady,  // Not full
  output wire [WIDTH-1:0] outData,  // Head word
  output wire             outValid, // Not empty
  input  wire             outReady  // Drain request
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_r;
  reg [AW-1:0]    rdPtr_r;
  reg [AW:0]      count_r;
  reg [AW:0]      count_nxt;
  reg             notFull_r;
  reg             notEmpty_r;
  wire            doWr;
  wire            doRd;

  // Flags are flops, so a port fed by them comes straight from a register
  assign inReady  = notFull_r;
  assign outValid = notEmpty_r;
  assign outData  = mem[rdPtr_r];
  assign doWr     = inValid & inReady;
  assign doRd     = outValid & outReady;

  // Occupancy after this cycle's push and pop
  always @* begin
    count_nxt = count_r;
    if (doWr && !doRd)
      count_nxt = count_r + 1'b1;
    else if (doRd && !doWr)
      count_nxt = count_r - 1'b1;
  end

  // Pointers wrap on depth, count tracks occupancy
  always @(posedge mclk) begin
    if (rst) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r    <= {(AW+1){1'b0}};
      notFull_r  <= 1'b1;
      notEmpty_r <= 1'b0;
    end else begin
      if (doWr) begin
        mem[wrPtr_r] <= inData;
        wrPtr_r      <= (wrPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
      end
      if (doRd)
        rdPtr_r <= (rdPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
      count_r    <= count_nxt;
      notFull_r  <= (count_nxt != DEPTH[AW:0]);
      notEmpty_r <= (count_nxt != {(AW+1){1'b0}});
    end
  end
endmodule // rsp_fifo
`default_nettype wire

// [design/rsp_host.v]
// Host-side master for the radio's four-wire serial config and data port.
// Assumes the device samples on rising serial clock, shifts on falling one.
`include "rsp_consts.vh"
`default_nettype none
module rsp_host #(
  parameter PD_WAIT_CYC = `RSP_PD_WAIT_CYC, // Fallback start-up wait in mclk cycles
  parameter FIFO_DEPTH  = 8                 // Transmit data FIFO depth
) (
  input  wire       mclk,          // System clock 200 MHz
  input  wire       rst,           // Sync reset, active high
  input  wire       cmdValid,      // Start a transaction
  output reg        cmdReady,      // Idle, command accepted
  input  wire       cmdWrite,      // 1 = write
  input  wire       cmdBurst,      // Burst flag
  input  wire [5:0] cmdAddr,       // Register address
  input  wire [5:0] cmdLen,        // Data bytes, 0 = header only
  input  wire       cmdNoWait,     // 1 = timed wait, no ready polling
  input  wire [7:0] wrData,        // Write data byte
  input  wire       wrValid,       // Write data valid
  output wire       wrReady,       // FIFO has room
  output reg  [7:0] rdData,        // Byte read or status byte
  output reg        rdValid,       // One-cycle pulse per byte
  output reg        rdIsStatus,    // rdData is a status byte
  output reg        done,          // One-cycle pulse at end
  output reg        serialClk,     // Serial clock to device
  output reg        serialIn,      // Device data input
  input  wire       serialOut,     // Device data output
  output reg        chip_select_low // Active-low chip select
);
  // Frame walk, one state per phase:
  //   idle - ready for a command, select high, clock low
  //   wait - select low, polling the ready flag or timing the start-up
  //   low  - clock low half-period, data bit already on the line
  //   high - clock high half-period, returned bit captured on entry
  //   gap  - byte gap; a write also waits here for its next data byte
  //   end  - select held past the last falling clock edge, then released
  localparam S_IDLE = 3'd0;
  localparam S_WAIT = 3'd1;
  localparam S_LOW  = 3'd2;
  localparam S_HIGH = 3'd3;
  localparam S_GAP  = 3'd4;
  localparam S_END  = 3'd5;

  // Timing counts cut to the 18-bit timer on purpose
  localparam integer HALF_I     = `RSP_SCLK_HALF_CYC - 1;
  localparam integer GAP_I      = `RSP_BYTE_GAP_CYC - 1;
  localparam integer SETTLE_I   = `RSP_SYNC_SETTLE_CYC;
  localparam [17:0]  HALF_LAST  = HALF_I[17:0];
  localparam [17:0]  GAP_LAST   = GAP_I[17:0];
  localparam [17:0]  SETTLE_CYC = SETTLE_I[17:0];
  localparam [17:0]  PD_LAST    = PD_WAIT_CYC[17:0];

  // Sequencer state and bit timing
  reg  [2:0]  state_r;
  reg  [17:0] tmr_r;
  reg  [2:0]  bit_r;

  // Shift registers, one per direction
  reg  [7:0]  txSh_r;
  reg  [7:0]  rxSh_r;

  // Transaction context latched at the take
  reg         hdr_r;
  reg         write_r;
  reg         noWait_r;
  reg  [5:0]  left_r;

  // Ready flag synchroniser, idles high
  reg         so1_r;
  reg         so2_r;

  // Transmit data FIFO read side
  wire [7:0]  fData;
  wire        fValid;
  reg         fPop;

  // Exit conditions of the wait state
  wire        readySeen;
  wire        waitOver;

  // Write data waits here; address width follows the depth
  rsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW($clog2(FIFO_DEPTH))) uFifo (
    .mclk(mclk), .rst(rst), .inData(wrData), .inValid(wrValid), .inReady(wrReady),
    .outData(fData), .outValid(fValid), .outReady(fPop)
  );

  // Poll only once the synchroniser holds a sample taken after select fell;
  // before that it may still show the released line's last level
  assign readySeen = !noWait_r && !so2_r && (tmr_r >= SETTLE_CYC);
  assign waitOver  = noWait_r && (tmr_r >= PD_LAST);

  // Two-flop synchroniser on the device data output
  always @(posedge mclk) begin
    if (rst) begin
      so1_r <= 1'b1;
      so2_r <= 1'b1;
    end else begin
      so1_r <= serialOut;
      so2_r <= so1_r;
    end
  end

  // Main sequencer; 50 ns half-periods run at the 10 MHz limit, so every byte gets the 100 ns gap
  always @(posedge mclk) begin
    fPop <= 1'b0;
    if (rst) begin
      state_r         <= S_IDLE;
      cmdReady        <= 1'b0;
      chip_select_low <= 1'b1;
      serialClk       <= 1'b0;
      serialIn        <= 1'b0;
      rdData          <= 8'h00;
      rdValid         <= 1'b0;
      rdIsStatus      <= 1'b0;
      done            <= 1'b0;
      tmr_r           <= 18'h0_0000;
      bit_r           <= 3'd0;
      txSh_r          <= 8'h00;
      rxSh_r          <= 8'h00;
      hdr_r           <= 1'b0;
      write_r         <= 1'b0;
      noWait_r        <= 1'b0;
      left_r          <= 6'd0;
    end else begin
      rdValid <= 1'b0;
      done    <= 1'b0;
      case (state_r)
        S_IDLE: begin
          // Whole command latched; later input changes are ignored
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady) begin
            cmdReady        <= 1'b0;
            chip_select_low <= 1'b0;
            txSh_r          <= {cmdWrite ? 1'b0 : 1'b1, cmdBurst, cmdAddr};
            write_r         <= cmdWrite;
            noWait_r        <= cmdNoWait;
            left_r          <= cmdLen;
            hdr_r           <= 1'b1;
            bit_r           <= 3'd7;
            tmr_r           <= 18'h0_0000;
            state_r         <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Poll ready, or fall back to the timed start-up wait
          tmr_r <= tmr_r + 1'b1;
          if (readySeen || waitOver) begin
            tmr_r    <= 18'h0_0000;
            serialIn <= txSh_r[7];
            state_r  <= S_LOW;
          end
        end
        S_LOW: begin
          // Capture at the rise; data out last moved at a falling edge
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r >= HALF_LAST) begin
            tmr_r     <= 18'h0_0000;
            serialClk <= 1'b1;
            rxSh_r    <= {rxSh_r[6:0], so2_r};
            state_r   <= S_HIGH;
          end
        end
        S_HIGH: begin
          // Falling edge carries the next bit out
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r >= HALF_LAST) begin
            tmr_r     <= 18'h0_0000;
            serialClk <= 1'b0;
            txSh_r    <= {txSh_r[6:0], 1'b0};
            if (bit_r != 3'd0) begin
              bit_r    <= bit_r - 1'b1;
              serialIn <= txSh_r[6];
              state_r  <= S_LOW;
            end else begin
              // Byte complete: hand back status or read data
              rdData     <= rxSh_r;
              rdValid    <= 1'b1;
              rdIsStatus <= hdr_r | write_r;
              hdr_r      <= 1'b0;
              bit_r      <= 3'd7;
              state_r    <= (left_r == 6'd0) ? S_END : S_GAP;
            end
          end
        end
        S_GAP: begin
          // Inter-byte gap; a write stalls here until its data byte arrives
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r >= GAP_LAST && (!write_r || fValid)) begin
            tmr_r    <= 18'h0_0000;
            left_r   <= left_r - 1'b1;
            txSh_r   <= write_r ? fData : 8'h00;
            serialIn <= write_r ? fData[7] : 1'b0;
            fPop     <= write_r;
            state_r  <= S_LOW;
          end
        end
        S_END: begin
          // Hold select past last falling edge, then release
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r >= GAP_LAST) begin
            chip_select_low <= 1'b1;
            serialIn        <= 1'b0;
            done            <= 1'b1;
            tmr_r           <= 18'h0_0000;
            state_r         <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // rsp_host
`default_nettype wire

// [testbench/rsp_host_checker.sv]
// Frame and clock shape checks for the serial host port.
// Bound onto rsp_host; sees its ports only.
`default_nettype none
module rsp_host_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic rdValid,
  input wire logic done,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic chip_select_low
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Clock low run and falls per byte, for the byte gap check
  logic [2:0] fallCnt;
  logic [7:0] lowRun;
  logic       seen;
  always @(posedge mclk) begin
    if (rst || chip_select_low) begin
      fallCnt <= 3'd0;
      lowRun  <= 8'd0;
      seen    <= 1'b0;
    end else begin
      if ($fell(serialClk)) begin
        fallCnt <= fallCnt + 3'd1;
        seen    <= 1'b1;
      end
      lowRun <= serialClk ? 8'd0 : ((lowRun == 8'hFF) ? lowRun : lowRun + 8'd1);
    end
  end
  // Between bytes the clock stays low for half a period plus the gap
  byte_gap_a: assert property ($rose(serialClk) && seen && fallCnt == 0 |-> lowRun >= 30) else $error("gap");
  // A take opens the frame on the next cycle
  take_opens_a: assert property (cmdValid && cmdReady |=> !chip_select_low) else $error("no select");
  busy_frame_a: assert property (!chip_select_low |-> !cmdReady) else $error("ready in frame");
  idle_clock_a: assert property (chip_select_low |-> !serialClk) else $error("clock idle");
  ready_wait_a: assert property ($fell(chip_select_low) |-> !serialClk[*8]) else $error("early clock");
  high_time_a: assert property ($rose(serialClk) |-> serialClk[*8]) else $error("short high");
  low_time_a: assert property ($fell(serialClk) |-> !serialClk[*8]) else $error("short low");
  // Data may only move while the clock is low
  data_hold_a: assert property (serialClk && $past(serialClk) |-> $stable(serialIn)) else $error("data moved");
  done_close_a: assert property (done |-> $rose(chip_select_low) && !cmdReady ##1 !done && cmdReady) else $error("close");
  read_pulse_a: assert property (rdValid |=> !rdValid) else $error("long pulse");
  cover property (done);
  cover property (rdValid);
  cover property ($rose(serialClk));
endmodule // rsp_host_checker
bind rsp_host rsp_host_checker chk (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .rdValid(rdValid), .done(done), .serialClk(serialClk), .serialIn(serialIn), .chip_select_low(chip_select_low));
`default_nettype wire

// [testbench/rsp_dev_model.sv]
// Behavioural radio device on the far side of the serial port.
// Assumes rising-edge sampling; 64 byte register space.
`default_nettype none
module rsp_dev_model (
  input wire logic        rst,
  input wire logic        csLow,
  input wire logic        sclk,
  input wire logic        sdi,
  output var logic        sdo,
  input wire logic [31:0] rdyNs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [64];
  logic [7:0] hdr, sh, outB;
  logic [5:0] addr;
  int cnt, nb;
  initial sdo = 1'b1;
  // Defaults come back as reset is released
  always @(negedge rst) for (int i = 0; i < 64; i++) mem[i] = 8'hA5 ^ 8'(i);
  // Fresh counters per frame; half bytes are dropped
  always @(negedge csLow) begin
    cnt = 0;
    nb = 0;
    sdo = 1'b1;
    outB = 8'h0F;
    #(rdyNs) if (!csLow) sdo = 1'b0; // Ready flag low once stable
  end
  always @(posedge csLow) sdo = ~sdo; // Released line shows no stale bit
  always @(posedge sclk) if (!csLow) begin
    sh = {sh[6:0], sdi};
    cnt++;
    if (cnt == 8) begin
      cnt = 0;
      if (nb == 0) {hdr, addr} = {sh, sh[5:0]};
      else begin
        if (!hdr[7]) mem[addr] = sh;
        if (hdr[6]) addr++;
      end
      nb++;
      outB = hdr[7] ? mem[addr] : 8'h0F; // Status on header and writes
    end
  end
  always @(negedge sclk) if (!csLow) sdo = outB[7 - cnt];
endmodule // rsp_dev_model
`default_nettype wire

// [testbench/spi_config_slave_port_test.sv]
// Self-checking bench: host controller against the device model.
// Assumes model status 0x0F and defaults A5 xor address.
`default_nettype none
module spi_config_slave_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, cmdValid = 0, cmdWrite = 0, cmdBurst = 0, cmdNoWait = 0, wrValid = 0;
  logic [5:0] cmdAddr = 0, cmdLen = 0;
  logic [7:0] wrData = 0, rdData;
  logic cmdReady, wrReady, rdValid, rdIsStatus, done, serialClk, serialIn, serialOut, chip_select_low;
  int bad_count = 0, total_checks = 0, rdyNs = 20;
  logic [8:0] expQ[$];
  logic [7:0] refMem [64];
  rsp_host #(.PD_WAIT_CYC(50), .FIFO_DEPTH(8)) dut (.mclk(mclk), .rst(rst), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdBurst(cmdBurst), .cmdAddr(cmdAddr), .cmdLen(cmdLen),
    .cmdNoWait(cmdNoWait), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady), .rdData(rdData),
    .rdValid(rdValid), .rdIsStatus(rdIsStatus), .done(done), .serialClk(serialClk), .serialIn(serialIn),
    .serialOut(serialOut), .chip_select_low(chip_select_low));
  rsp_dev_model dev (.rst(rst), .csLow(chip_select_low), .sclk(serialClk), .sdi(serialIn),
    .sdo(serialOut), .rdyNs(rdyNs));
  initial forever #2.5 mclk = ~mclk;
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Oldest note against each byte that comes back
  always @(posedge mclk) if (rdValid === 1'b1) begin
    if (expQ.size() == 0) check({rdIsStatus, rdData}, 9'h1FF);
    else check({rdIsStatus, rdData}, expQ.pop_front());
  end
  // Load the FIFO with random bytes and note them
  task automatic fill(input logic [5:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk) #1;
      wrValid = 1;
      wrData = 8'($urandom);
      refMem[6'(a + i)] = wrData;
      do @(posedge mclk); while (wrReady !== 1'b1);
      #1 wrValid = 0;
    end
  endtask
  task automatic xfer(input logic w, input logic b, input logic nw, input logic [5:0] a, input int n);
    expQ.push_back(9'h10F);
    for (int i = 0; i < n; i++) expQ.push_back(w ? 9'h10F : {1'b0, refMem[6'(a + i * b)]});
    @(posedge mclk) #1;
    {cmdValid, cmdWrite, cmdBurst, cmdNoWait, cmdAddr, cmdLen} = {1'b1, w, b, nw, a, 6'(n)};
    do @(posedge mclk); while (cmdReady !== 1'b1);
    #1 cmdValid = 0;
    for (int k = 0; k < 9000 && done !== 1'b1; k++) @(posedge mclk);
    if (done !== 1'b1) bad_count++; // Frame never closed
    $display("test end addr=%h len=%0d", a, n);
  endtask
  initial begin
    void'($urandom(34335));
    for (int i = 0; i < 64; i++) refMem[i] = 8'hA5 ^ 8'(i);
    repeat (16) @(posedge mclk);
    #1 rst = 0;
    repeat (3) @(posedge mclk);
    xfer(0, 1, 0, 6'h20, 4); // Defaults read back
    fill(6'h05, 1);
    xfer(1, 0, 0, 6'h05, 1);
    xfer(0, 0, 0, 6'h05, 1); // Single write then read
    fill(6'h08, 8);
    check({8'h00, wrReady}, 9'h000); // FIFO refuses when full
    xfer(1, 1, 0, 6'h08, 8);
    xfer(0, 1, 0, 6'h08, 8); // Burst round trip
    xfer(1, 0, 0, 6'h30, 0); // Strobe, status only
    xfer(0, 1, 0, 6'h31, 1); // Status register read
    rdyNs = 1000;
    xfer(0, 1, 0, 6'h3F, 3); // Slow ready, address wraps
    rdyNs = 200;
    xfer(0, 0, 1, 6'h05, 1); // Timed wait instead of polling
    repeat (5) @(posedge mclk);
    check(9'(expQ.size()), 9'h000);
    conclude();
  end
  // Hang guard, far beyond the expected run
  initial begin
    #400_000;
    bad_count++;
    conclude();
  end
endmodule // spi_config_slave_port_test
`default_nettype wire
